// ==== pkg/tcm_pkg.sv ====
// Constants for the timer counter, modulo and channel flag block
package tcm_pkg;
	// =========================================================
	// Register byte addresses, one aligned word each
	localparam logic [7:0] ADR_TIMER_SC = 8'h00;
	localparam logic [7:0] ADR_CNT_HI = 8'h04;
	localparam logic [7:0] ADR_CNT_LO = 8'h08;
	localparam logic [7:0] ADR_MOD_HI = 8'h0c;
	localparam logic [7:0] ADR_MOD_LO = 8'h10;
	localparam logic [7:0] ADR_CHAN_SC = 8'h14;
	localparam logic [7:0] ADR_CHVAL_HI = 8'h18;
	localparam logic [7:0] ADR_CHVAL_LO = 8'h1c;
	// =========================================================
	// Field positions
	localparam int FLAG_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int CPWM_BIT = 5;
	localparam int CLKSEL_HI = 4;
	localparam int CLKSEL_LO = 3;
	localparam int MSB_BIT = 5;
	localparam int MSA_BIT = 4;
	localparam int EDGE_HI = 3;
	localparam int EDGE_LO = 2;
	// =========================================================
	// Values
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] MOD_RESET = 16'h0000;
	localparam logic [1:0] CLKSEL_OFF = 2'h0;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	localparam logic [6:0] CTL_RESET = 7'h00;
	localparam logic [4:0] CHCTL_RESET = 5'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// =========================================================
	// Counter read coherency states
	typedef enum logic [2:0] {
		COH_IDLE = 3'b001,
		COH_WAIT_LO = 3'b010,
		COH_WAIT_HI = 3'b100
	} tcm_coh_type;
	// Modulo write buffer states
	typedef enum logic [3:0] {
		MOD_IDLE = 4'b0001,
		MOD_HAVE_HI = 4'b0010,
		MOD_HAVE_LO = 4'b0100,
		MOD_ARMED = 4'b1000
	} tcm_mod_type;
endpackage

// ==== rtl/tcm_timer.sv ====
// Timer counter, modulo buffer and channel event flag with Wishbone slave
//
// How it works
// RL1 - Reading either counter byte holds both bytes until the other is read.
// RL2 - Reset or any timer control write returns the read hold to idle.
// RL3 - Reset or any counter byte write clears the counter and read hold.
// RL4 - Debug halt stops the counter; reads return the held value.
// RL5 - Debug halt freezes the counter read hold state despite reads.
// RL6 - In debug halt, control or counter writes still release the read hold.
// RL7 - At the modulo value the next tick restarts at zero, sets overflow flag.
// RL8 - One modulo byte written alone suppresses the overflow flag.
// RL9 - Modulo resets to zero; zero means free running over full range.
// RL10 - Modulo writes buffered; clock off loads them on the second byte.
// RL11 - Clock on loads buffered modulo at the step into the old modulo.
// RL12 - A timer control write resets the modulo buffer state, even halted.
// RL13 - In debug halt the modulo state freezes and writes go direct.
// RL14 - Software should clear the counter before writing a new modulo.
// RL15 - Input capture channel sets its event flag on an active edge.
// RL16 - Compare or PWM channel sets its flag when counter equals value; here only while edge_on is set.
// RL17 - PWM at 0% or 100% duty never sets the channel flag.
// RL18 - Channel interrupt requested while flag set and enable is one.
// RL19 - Channel flag clears by read then write 0; new event restarts.
// RL20 - Reset clears the channel flag; writing 1 leaves it alone.
// RL21 - Clock select zero stops the counter; other codes let ticks through.
// RL22 - Overflow flag clears by read then write 0; writing 1 does nothing.
// RL23 - Free running counter wraps from maximum to zero and sets overflow.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module tcm_timer
	import tcm_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic timer_tick_in,
	input wire logic debug_halt_in,
	input wire logic capture_edge_in,
	output logic overflow_irq_out,
	output logic channel_irq_out
);
	// =========================================================
	// Helpers
	// Set wins over clear so no event is lost in the clearing cycle
	function automatic logic flag_next(input logic flag, input logic set, input logic clr);
		flag_next = set | (flag & ~clr);
	endfunction
	// Read arm of the clear sequence; a new event restarts it
	function automatic logic arm_next(input logic arm, input logic flag, input logic set,
		input logic rd, input logic wr);
		if (set) begin
			arm_next = 1'b0;
		end else if (rd & flag) begin
			arm_next = 1'b1;
		end else if (wr) begin
			arm_next = 1'b0;
		end else begin
			arm_next = arm;
		end
	endfunction
	// Effective top of count
	function automatic logic [15:0] top_of(input logic [15:0] m);
		top_of = (m == MOD_RESET) ? CNT_MAX : m;
	endfunction

	// =========================================================
	// Bus decode
	logic ack_ff;
	logic [31:0] dat_ff;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	assign acc = wb_cyc_in & wb_stb_in & ~ack_ff;
	assign wr = acc & wb_we_in & wb_sel_in[0];
	assign rd = acc & ~wb_we_in;
	assign wbyte = wb_dat_in[7:0];

	logic sc_wr, cnt_wr, modh_wr, modl_wr, csc_wr, cvh_wr, cvl_wr;
	logic sc_rd, cnth_rd, cntl_rd, csc_rd;
	assign sc_wr = wr & (wb_adr_in == ADR_TIMER_SC);
	assign cnt_wr = wr & ((wb_adr_in == ADR_CNT_HI) | (wb_adr_in == ADR_CNT_LO));
	assign modh_wr = wr & (wb_adr_in == ADR_MOD_HI);
	assign modl_wr = wr & (wb_adr_in == ADR_MOD_LO);
	assign csc_wr = wr & (wb_adr_in == ADR_CHAN_SC);
	assign cvh_wr = wr & (wb_adr_in == ADR_CHVAL_HI);
	assign cvl_wr = wr & (wb_adr_in == ADR_CHVAL_LO);
	assign sc_rd = rd & (wb_adr_in == ADR_TIMER_SC);
	assign cnth_rd = rd & (wb_adr_in == ADR_CNT_HI);
	assign cntl_rd = rd & (wb_adr_in == ADR_CNT_LO);
	assign csc_rd = rd & (wb_adr_in == ADR_CHAN_SC);

	// =========================================================
	// State
	logic [15:0] cnt_ff, cnt_buf_ff, mod_ff, mod_buf_ff, chval_ff;
	logic [6:0] ctl_ff;
	logic [4:0] chctl_ff;
	// Channel control keeps only byte bits 6:2, so its field positions shift down by this much
	localparam int CH_LSB = EDGE_LO;
	logic ovf_flag_ff, ovf_arm_ff, ch_flag_ff, ch_arm_ff;
	logic ovf_irq_ff, ch_irq_ff;
	tcm_coh_type coh_ff;
	tcm_mod_type mst_ff;

	logic [1:0] clk_sel;
	logic step, wrap, ovf_evt, mod_upd, one_byte;
	logic [15:0] nxt_cnt, top;
	assign clk_sel = ctl_ff[CLKSEL_HI:CLKSEL_LO];
	assign top = top_of(mod_ff);
	// Ticks only pass with a clock source chosen and no debug halt
	assign step = timer_tick_in & (clk_sel != CLKSEL_OFF) & ~debug_halt_in; // RL21 RL4
	assign wrap = (cnt_ff == top); // RL7 RL9 RL23
	assign nxt_cnt = wrap ? CNT_ZERO : cnt_ff + CNT_ONE;
	assign one_byte = (mst_ff == MOD_HAVE_HI) | (mst_ff == MOD_HAVE_LO);
	assign ovf_evt = step & wrap & ~cnt_wr & ~one_byte; // RL8
	// Load point is the step into the old top, so the new limit starts cleanly
	assign mod_upd = step & (mst_ff == MOD_ARMED) & (cnt_ff == top - CNT_ONE); // RL11

	// =========================================================
	// Wishbone answer, one cycle after the request
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= acc;
		end
	end

	// Read data mux; unmapped addresses read zero
	logic [15:0] cnt_view;
	assign cnt_view = (coh_ff == COH_IDLE) ? cnt_ff : cnt_buf_ff; // RL1
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dat_ff <= WORD_ZERO;
		end else if (rd) begin
			unique case (wb_adr_in)
				ADR_TIMER_SC: dat_ff <= {24'h000000, ovf_flag_ff, ctl_ff};
				ADR_CNT_HI: dat_ff <= {24'h000000, cnt_view[15:8]};
				ADR_CNT_LO: dat_ff <= {24'h000000, cnt_view[7:0]};
				ADR_MOD_HI: dat_ff <= {24'h000000, mod_ff[15:8]};
				ADR_MOD_LO: dat_ff <= {24'h000000, mod_ff[7:0]};
				ADR_CHAN_SC: dat_ff <= {24'h000000, ch_flag_ff, chctl_ff, 2'h0};
				ADR_CHVAL_HI: dat_ff <= {24'h000000, chval_ff[15:8]};
				ADR_CHVAL_LO: dat_ff <= {24'h000000, chval_ff[7:0]};
				default: dat_ff <= WORD_ZERO;
			endcase
		end
	end

	// =========================================================
	// Control registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctl_ff <= CTL_RESET;
			chctl_ff <= CHCTL_RESET;
		end else begin
			if (sc_wr) begin
				ctl_ff <= wbyte[6:0];
			end
			if (csc_wr) begin
				chctl_ff <= wbyte[IRQ_EN_BIT:CH_LSB];
			end
		end
	end

	// =========================================================
	// Counter; a write clears it regardless of data
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_ff <= CNT_ZERO; // RL3
		end else if (cnt_wr) begin
			cnt_ff <= CNT_ZERO; // RL3
		end else if (step) begin
			cnt_ff <= nxt_cnt; // RL7 RL23
		end
	end

	// Read coherency; control and counter writes release it even under debug halt
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			coh_ff <= COH_IDLE; // RL2
		end else if (sc_wr | cnt_wr) begin
			coh_ff <= COH_IDLE; // RL2 RL3 RL6
		end else if (!debug_halt_in) begin // RL5
			unique case (coh_ff)
				COH_IDLE: begin
					if (cnth_rd) begin
						coh_ff <= COH_WAIT_LO; // RL1
					end else if (cntl_rd) begin
						coh_ff <= COH_WAIT_HI; // RL1
					end
				end
				COH_WAIT_LO: begin
					if (cntl_rd) begin
						coh_ff <= COH_IDLE;
					end
				end
				COH_WAIT_HI: begin
					if (cnth_rd) begin
						coh_ff <= COH_IDLE;
					end
				end
			endcase
		end
	end

	// Snapshot of both bytes at the first read
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_buf_ff <= CNT_ZERO;
		end else if ((coh_ff == COH_IDLE) & ~debug_halt_in & (cnth_rd | cntl_rd)) begin
			cnt_buf_ff <= cnt_ff; // RL1
		end
	end

	// =========================================================
	// Modulo write buffer state
	logic mod_done;
	assign mod_done = ((mst_ff == MOD_HAVE_HI) & modl_wr) | ((mst_ff == MOD_HAVE_LO) & modh_wr);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mst_ff <= MOD_IDLE;
		end else if (sc_wr) begin
			mst_ff <= MOD_IDLE; // RL12
		end else if (!debug_halt_in) begin // RL13
			if (mod_done) begin
				mst_ff <= (clk_sel == CLKSEL_OFF) ? MOD_IDLE : MOD_ARMED; // RL10 RL11
			end else if (modh_wr) begin
				mst_ff <= MOD_HAVE_HI;
			end else if (modl_wr) begin
				mst_ff <= MOD_HAVE_LO;
			end else if (mod_upd) begin
				mst_ff <= MOD_IDLE;
			end
		end
	end

	// Buffer bytes, filled only outside debug halt
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mod_buf_ff <= MOD_RESET;
		end else if (!debug_halt_in) begin
			if (modh_wr) begin
				mod_buf_ff[15:8] <= wbyte; // RL10
			end
			if (modl_wr) begin
				mod_buf_ff[7:0] <= wbyte; // RL10
			end
		end
	end

	// Active modulo
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mod_ff <= MOD_RESET; // RL9
		end else if (debug_halt_in) begin
			if (modh_wr) begin
				mod_ff[15:8] <= wbyte; // RL13
			end
			if (modl_wr) begin
				mod_ff[7:0] <= wbyte; // RL13
			end
		end else if (mod_done & (clk_sel == CLKSEL_OFF)) begin
			mod_ff <= modh_wr ? {wbyte, mod_buf_ff[7:0]} : {mod_buf_ff[15:8], wbyte}; // RL10
		end else if (mod_upd) begin
			mod_ff <= mod_buf_ff; // RL11
		end
	end

	// =========================================================
	// Overflow flag and its clearing sequence
	logic ovf_clr;
	assign ovf_clr = sc_wr & ~wbyte[FLAG_BIT] & ovf_arm_ff; // RL22
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ovf_flag_ff <= 1'b0;
			ovf_arm_ff <= 1'b0;
		end else begin
			ovf_flag_ff <= flag_next(ovf_flag_ff, ovf_evt, ovf_clr); // RL7 RL22
			ovf_arm_ff <= arm_next(ovf_arm_ff, ovf_flag_ff, ovf_evt, sc_rd, sc_wr); // RL22
		end
	end

	// =========================================================
	// Channel value; ignored while capturing
	logic is_capture, is_pwm, edge_on, duty_edge, ch_evt, ch_clr;
	// Byte positions rebased onto the stored field, else the selects run past bit 4
	assign edge_on = chctl_ff[EDGE_HI - CH_LSB:EDGE_LO - CH_LSB] != EDGE_OFF;
	assign is_capture = ~ctl_ff[CPWM_BIT] &
		(chctl_ff[MSB_BIT - CH_LSB:MSA_BIT - CH_LSB] == MODE_CAPTURE);
	assign is_pwm = ctl_ff[CPWM_BIT] | chctl_ff[MSB_BIT - CH_LSB];
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chval_ff <= CNT_ZERO;
		end else if (!is_capture) begin
			if (cvh_wr) begin
				chval_ff[15:8] <= wbyte;
			end
			if (cvl_wr) begin
				chval_ff[7:0] <= wbyte;
			end
		end
	end

	// Zero value gives 0%, a value past the top gives 100%
	assign duty_edge = (chval_ff == CNT_ZERO) | (chval_ff > top); // RL17
	always_comb begin
		ch_evt = 1'b0;
		if (edge_on) begin
			if (is_capture) begin
				ch_evt = capture_edge_in; // RL15
			end else begin
				// Match taken when the counter steps onto the value
				ch_evt = step & ~cnt_wr & (nxt_cnt == chval_ff) & ~(is_pwm & duty_edge); // RL16 RL17
			end
		end
	end
	assign ch_clr = csc_wr & ~wbyte[FLAG_BIT] & ch_arm_ff; // RL19 RL20

	// Channel flag and its clearing sequence
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ch_flag_ff <= 1'b0; // RL20
			ch_arm_ff <= 1'b0;
		end else begin
			ch_flag_ff <= flag_next(ch_flag_ff, ch_evt, ch_clr); // RL19
			ch_arm_ff <= arm_next(ch_arm_ff, ch_flag_ff, ch_evt, csc_rd, csc_wr); // RL19
		end
	end

	// =========================================================
	// Interrupt requests, registered one cycle behind the flags
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ovf_irq_ff <= 1'b0;
			ch_irq_ff <= 1'b0;
		end else begin
			ovf_irq_ff <= ovf_flag_ff & ctl_ff[IRQ_EN_BIT];
			ch_irq_ff <= ch_flag_ff & chctl_ff[IRQ_EN_BIT - CH_LSB]; // RL18
		end
	end

	assign wb_ack_out = ack_ff;
	assign wb_dat_out = dat_ff;
	assign overflow_irq_out = ovf_irq_ff;
	assign channel_irq_out = ch_irq_ff;

	// =========================================================
	// Checks
	AST_CNT_CLEAR: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
		cnt_wr |=> (cnt_ff == CNT_ZERO) && (coh_ff == COH_IDLE))
		else $error("counter write did not clear counter");
	AST_HALT_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL4
		(debug_halt_in && !cnt_wr) |=> $stable(cnt_ff))
		else $error("counter moved during debug halt");
	AST_COH_FROZEN: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL5
		(debug_halt_in && !sc_wr && !cnt_wr) |=> $stable(coh_ff))
		else $error("read hold changed during debug halt");
	AST_SC_RELEASE: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL6
		sc_wr |=> (coh_ff == COH_IDLE) && (mst_ff == MOD_IDLE))
		else $error("control write did not release latches");
	AST_WRAP: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL7
		(step && wrap && !cnt_wr && !one_byte) |=> (cnt_ff == CNT_ZERO) && ovf_flag_ff)
		else $error("counter did not wrap with overflow");
	AST_INHIBIT: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL8
		(one_byte && !ovf_flag_ff) |=> !ovf_flag_ff)
		else $error("overflow set with half written modulo");
	AST_HOLD_READ: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL1
		(cnth_rd && coh_ff == COH_IDLE && !debug_halt_in) |=>
		(coh_ff == COH_WAIT_LO) && (cnt_buf_ff == $past(cnt_ff)))
		else $error("counter read did not capture both bytes");
	AST_IRQ: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL18
		(ch_flag_ff && chctl_ff[IRQ_EN_BIT - CH_LSB]) |=> channel_irq_out)
		else $error("channel interrupt missing");
	AST_W1_KEEP: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL20
		(csc_wr && wbyte[FLAG_BIT] && ch_flag_ff) |=> ch_flag_ff)
		else $error("writing one changed channel flag");
	AST_CLK_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL21
		(clk_sel == CLKSEL_OFF && !cnt_wr) |=> $stable(cnt_ff))
		else $error("counter ran with no clock source");
endmodule

// ==== dv/tcm_timer_tb.sv ====
// Self-checking bench for the timer counter, modulo and channel flag block
`timescale 1ns/100ps
module tcm_timer_tb
	import tcm_pkg::*;
;
	// ============================================================
	// Bench signals
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'hf;
	logic [31:0] wb_dat_in = 32'h0000_0000;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic timer_tick_in = 1'b0;
	logic debug_halt_in = 1'b0;
	logic capture_edge_in = 1'b0;
	logic overflow_irq_out;
	logic channel_irq_out;
	int fails = 0;
	int num_checks = 0;
	logic [31:0] rd_data;

	// ============================================================
	// Design under test
	tcm_timer tcm_timer_inst (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out),
		.timer_tick_in(timer_tick_in),
		.debug_halt_in(debug_halt_in),
		.capture_edge_in(capture_edge_in),
		.overflow_irq_out(overflow_irq_out),
		.channel_irq_out(channel_irq_out)
	);

	// 200 MHz clock
	always #2.5 clk_in = ~clk_in;

	// ============================================================
	// Tasks
	// Verdict and end of run, also reached on a bus timeout
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Case equality so an unknown never passes
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic cycle: request held until ack is sampled high at an edge
	task automatic bus(input logic w, input logic [7:0] adr, input logic [7:0] dat);
		int n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= adr;
		wb_dat_in <= {24'h00_0000, dat};
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 16);
		rd_data = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		if (wb_ack_out !== 1'b1) begin
			fails++;
			$display("[FAIL] ack expected 1 seen %b", wb_ack_out);
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		bus(1'b1, adr, dat);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00);
		chk($sformatf("reg %h", adr), {24'h00_0000, exp}, rd_data);
	endtask

	// High byte first, so the low byte read releases the hold
	task automatic rdcnt(input logic [15:0] exp);
		rd(ADR_CNT_HI, exp[15:8]);
		rd(ADR_CNT_LO, exp[7:0]);
	endtask

	// Separate pulses, since the prescaler outside never gives two in a row
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_in);
			timer_tick_in <= 1'b1;
			@(posedge clk_in);
			timer_tick_in <= 1'b0;
		end
	endtask

	task automatic halt(input logic v);
		@(posedge clk_in);
		debug_halt_in <= v;
	endtask

	task automatic capture();
		@(posedge clk_in);
		capture_edge_in <= 1'b1;
		@(posedge clk_in);
		capture_edge_in <= 1'b0;
	endtask

	// Interrupt outputs lag the flags by one cycle
	task automatic irq_chk(input logic ovf, input logic chn);
		repeat (3) @(posedge clk_in);
		chk("overflow irq", {31'h0, ovf}, {31'h0, overflow_irq_out});
		chk("channel irq", {31'h0, chn}, {31'h0, channel_irq_out});
	endtask

	// ============================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		// Reset values, the last address is unmapped
		for (int a = 0; a <= 32; a += 4) begin
			rd(8'(a), 8'h00);
		end
		// Every clock select code, only code zero holds the counter
		for (int c = 0; c < 4; c++) begin
			wr(ADR_TIMER_SC, 8'(c << 3));
			wr(ADR_CNT_HI, 8'h5a);
			tick(3);
			rdcnt((c == 0) ? 16'h0000 : 16'h0003);
		end
		// Read hold in both byte orders
		wr(ADR_TIMER_SC, 8'h08);
		wr(ADR_CNT_LO, 8'ha5);
		tick(5);
		rd(ADR_CNT_HI, 8'h00);
		tick(2);
		rd(ADR_CNT_LO, 8'h05);
		rd(ADR_CNT_LO, 8'h07);
		tick(1);
		wr(ADR_TIMER_SC, 8'h08);
		rd(ADR_CNT_LO, 8'h08);
		tick(1);
		wr(ADR_CNT_HI, 8'hff);
		tick(2);
		rd(ADR_CNT_LO, 8'h02);
		rd(ADR_CNT_HI, 8'h00);
		// Hold taken before halt must survive reads during halt
		rd(ADR_CNT_HI, 8'h00);
		tick(1);
		halt(1'b1);
		tick(2);
		rd(ADR_CNT_LO, 8'h02);
		rd(ADR_CNT_LO, 8'h02);
		halt(1'b0);
		rd(ADR_CNT_LO, 8'h02);
		rdcnt(16'h0003);
		// Control write in halt still releases the hold
		rd(ADR_CNT_HI, 8'h00);
		halt(1'b1);
		wr(ADR_TIMER_SC, 8'h08);
		halt(1'b0);
		tick(1);
		rd(ADR_CNT_LO, 8'h04);
		rd(ADR_CNT_HI, 8'h00);
		// Modulo with clock off loads at once, then wrap and flag
		wr(ADR_TIMER_SC, 8'h00);
		wr(ADR_CNT_HI, 8'h00);
		wr(ADR_MOD_HI, 8'h00);
		wr(ADR_MOD_LO, 8'h05);
		rd(ADR_MOD_LO, 8'h05);
		wr(ADR_TIMER_SC, 8'h48);
		tick(5);
		rd(ADR_TIMER_SC, 8'h48);
		tick(1);
		rdcnt(16'h0000);
		rd(ADR_TIMER_SC, 8'hc8);
		irq_chk(1'b1, 1'b0);
		// Writing one is ignored, read then write zero clears
		wr(ADR_TIMER_SC, 8'hc8);
		rd(ADR_TIMER_SC, 8'hc8);
		wr(ADR_TIMER_SC, 8'h48);
		rd(ADR_TIMER_SC, 8'h48);
		irq_chk(1'b0, 1'b0);
		// One modulo byte alone hides overflow until control write
		wr(ADR_MOD_HI, 8'h00);
		tick(6);
		rd(ADR_TIMER_SC, 8'h48);
		wr(ADR_TIMER_SC, 8'h48);
		tick(6);
		rd(ADR_TIMER_SC, 8'hc8);
		wr(ADR_TIMER_SC, 8'h48);
		// Running clock defers the new modulo to the old top step
		wr(ADR_CNT_HI, 8'h00);
		tick(1);
		wr(ADR_MOD_HI, 8'h00);
		wr(ADR_MOD_LO, 8'h03);
		tick(3);
		rdcnt(16'h0004);
		rd(ADR_TIMER_SC, 8'h48);
		tick(1);
		wr(ADR_CNT_HI, 8'h00);
		tick(4);
		rdcnt(16'h0000);
		rd(ADR_TIMER_SC, 8'hc8);
		wr(ADR_TIMER_SC, 8'h48);
		// A single byte in halt goes straight to the active modulo
		halt(1'b1);
		wr(ADR_MOD_LO, 8'h06);
		halt(1'b0);
		wr(ADR_CNT_HI, 8'h00);
		tick(7);
		rdcnt(16'h0000);
		rd(ADR_TIMER_SC, 8'hc8);
		wr(ADR_TIMER_SC, 8'h08);
		// Capture flag, its interrupt, and a clear raced by a new edge
		wr(ADR_CHAN_SC, 8'h44);
		capture();
		rd(ADR_CHAN_SC, 8'hc4);
		irq_chk(1'b0, 1'b1);
		wr(ADR_CHAN_SC, 8'hc4);
		rd(ADR_CHAN_SC, 8'hc4);
		capture();
		wr(ADR_CHAN_SC, 8'h44);
		rd(ADR_CHAN_SC, 8'hc4);
		wr(ADR_CHAN_SC, 8'h44);
		rd(ADR_CHAN_SC, 8'h44);
		irq_chk(1'b0, 1'b0);
		// Compare match sets the flag only on the equal count
		wr(ADR_CHAN_SC, 8'h14);
		wr(ADR_CHVAL_HI, 8'h00);
		wr(ADR_CHVAL_LO, 8'h03);
		wr(ADR_CNT_HI, 8'h00);
		tick(2);
		rd(ADR_CHAN_SC, 8'h14);
		tick(1);
		rd(ADR_CHAN_SC, 8'h94);
		wr(ADR_CHAN_SC, 8'h14);
		// PWM with value zero is a 0% duty and never flags
		wr(ADR_CHAN_SC, 8'h28);
		wr(ADR_CHVAL_LO, 8'h00);
		wr(ADR_CNT_HI, 8'h00);
		tick(8);
		rd(ADR_CHAN_SC, 8'h28);
		// Center PWM turns a mode 00 channel into a compare, not a capture
		wr(ADR_TIMER_SC, 8'h28);
		wr(ADR_CHAN_SC, 8'h08);
		wr(ADR_CHVAL_LO, 8'h03);
		wr(ADR_CNT_HI, 8'h00);
		tick(2);
		rd(ADR_CHAN_SC, 8'h08);
		tick(1);
		rd(ADR_CHAN_SC, 8'h88);
		conclude();
	end
endmodule
